/* logic/pll_filter_and_scratch_regs.sv */
// loop filter control, oscillator band readback and spare byte registers
`timescale 1ns/1ns
module pll_filter_and_scratch_regs
   import pll_regs_pkg::*;
(
   // clock and reset
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   // register access from the serial port
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   input  wire logic [pll_regs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [pll_regs_pkg::DATA_W-1:0] reg_wdata,
   output logic      [pll_regs_pkg::DATA_W-1:0] reg_rdata,
   output logic                             reg_rvalid,
   // oscillator calibration result
   input  wire logic [pll_regs_pkg::BAND_W-1:0] oscillator_band_readback,
   // loop filter controls
   output logic      [pll_regs_pkg::CAP_W-1:0]  filter_capacitor_select,
   output logic                             filter_bias_enable,
   output logic                             filter_amplifier_enable
);
   import pll_regs_pkg::*;

   logic [BAND_W-1:0] band_s1_q;
   logic [BAND_W-1:0] band_q;
   logic              spare_hit;
   logic [DATA_W-1:0] spare_rdata;
   logic              rd_pend_q;

   function automatic logic is_spare(input logic [ADDR_W-1:0] a);
      return (a == SPARE_TWO_OFS) || (a == SPARE_THREE_OFS);
   endfunction : is_spare

   assign spare_hit = is_spare(reg_addr);

   // filter control fields; bits 7:6 are not stored
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         filter_capacitor_select <= CAP_RST;
         filter_bias_enable      <= BIAS_EN_RST;
         filter_amplifier_enable <= AMP_EN_RST;
      end else if (reg_wr && reg_addr == FILTER_CONTROL_OFS) begin
         filter_capacitor_select <= reg_wdata[CAP_LSB_POS +: CAP_W];
         filter_bias_enable      <= reg_wdata[BIAS_EN_POS];
         filter_amplifier_enable <= reg_wdata[AMP_EN_POS];
      end
   end

   // band value comes from the analog side, so synchronise it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         band_s1_q <= '0;
         band_q    <= '0;
      end else begin
         band_s1_q <= oscillator_band_readback;
         band_q    <= band_s1_q;
      end
   end

   spare_byte_store u_spare (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .wr_en   (reg_wr && spare_hit),
      .wr_sel  (reg_addr[0]),
      .wr_data (reg_wdata),
      .rd_sel  (reg_addr[0]),
      .rd_data (spare_rdata)
   );

   // read data one cycle after the request, two cycles after it for the spare bytes
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rvalid <= 1'b0;
         reg_rdata  <= '0;
      end else begin
         reg_rvalid <= (reg_rd && !spare_hit) || rd_pend_q;
         if (rd_pend_q) begin
            reg_rdata <= spare_rdata;
         end else if (reg_rd) begin
            unique case (reg_addr)
               FILTER_CONTROL_OFS:
                  reg_rdata <= {2'b00, filter_capacitor_select, filter_bias_enable,
                                filter_amplifier_enable};
               OSC_BAND_OFS:
                  reg_rdata <= {3'b000, band_q};
               default:
                  reg_rdata <= '0;
            endcase
         end
      end
   end

   // scratch read data arrive from the store a cycle later; answer then
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_pend_q <= 1'b0;
      end else begin
         rd_pend_q <= reg_rd && spare_hit;
      end
   end

   // assertions
   bias_reset_a: assert property (@(posedge mclk) $rose(!sys_rst) |-> filter_bias_enable)
      else $error("bias enable not set after reset");

   amp_reset_a: assert property (@(posedge mclk) $rose(!sys_rst) |-> filter_amplifier_enable)
      else $error("amplifier enable not set after reset");

   cap_reset_a: assert property (@(posedge mclk)
      $rose(!sys_rst) |-> filter_capacitor_select == CAP_RST)
      else $error("capacitor select not at default after reset");

   amp_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == FILTER_CONTROL_OFS |=> filter_amplifier_enable == $past(reg_wdata[0]))
      else $error("amplifier enable did not follow write");

   bias_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == FILTER_CONTROL_OFS |=> filter_bias_enable == $past(reg_wdata[1]))
      else $error("bias enable did not follow write");

   cap_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == FILTER_CONTROL_OFS
      |=> filter_capacitor_select == $past(reg_wdata[5:2]))
      else $error("capacitor select did not follow write");

   cap_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(reg_wr && reg_addr == FILTER_CONTROL_OFS) |=> $stable(filter_capacitor_select))
      else $error("capacitor select changed without write");

   bias_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(reg_wr && reg_addr == FILTER_CONTROL_OFS) |=> $stable(filter_bias_enable))
      else $error("bias enable changed without write");

   amp_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(reg_wr && reg_addr == FILTER_CONTROL_OFS) |=> $stable(filter_amplifier_enable))
      else $error("amplifier enable changed without write");

   band_sync_a: assert property (@(posedge mclk) disable iff (sys_rst)
      1'b1 |=> band_s1_q == $past(oscillator_band_readback))
      else $error("band first stage did not follow input");

   band_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_rd && reg_addr == OSC_BAND_OFS |=> reg_rvalid && reg_rdata[7:5] == 3'b000
      && reg_rdata[4:0] == $past(band_q))
      else $error("band readback wrong");

   band_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == OSC_BAND_OFS |=> band_q == $past(band_s1_q))
      else $error("band register disturbed by write");

   band_iso_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == OSC_BAND_OFS
      |=> $stable(filter_capacitor_select) && $stable(filter_bias_enable))
      else $error("band write touched filter control");

   spare_iso_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && spare_hit |=> $stable(filter_capacitor_select) && $stable(filter_bias_enable)
      && $stable(filter_amplifier_enable))
      else $error("spare write touched filter control");

   two_reset_a: assert property (@(posedge mclk)
      $rose(!sys_rst) |-> u_spare.mem_q[0] == SPARE_RST)
      else $error("spare byte two not cleared by reset");

   three_reset_a: assert property (@(posedge mclk)
      $rose(!sys_rst) |-> u_spare.mem_q[1] == SPARE_RST)
      else $error("spare byte three not cleared by reset");

   two_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == SPARE_TWO_OFS |=> u_spare.mem_q[0] == $past(reg_wdata))
      else $error("spare byte two did not take write");

   three_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == SPARE_THREE_OFS |=> u_spare.mem_q[1] == $past(reg_wdata))
      else $error("spare byte three did not take write");

   two_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(reg_wr && reg_addr == SPARE_TWO_OFS) |=> $stable(u_spare.mem_q[0]))
      else $error("spare byte two changed without write");

   three_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(reg_wr && reg_addr == SPARE_THREE_OFS) |=> $stable(u_spare.mem_q[1]))
      else $error("spare byte three changed without write");

   spare_rt_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_rd && spare_hit |=> rd_pend_q ##1 (reg_rvalid && reg_rdata == $past(spare_rdata)))
      else $error("spare byte readback wrong");

   ctl_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_rd && reg_addr == FILTER_CONTROL_OFS |=> reg_rdata[7:6] == 2'b00)
      else $error("filter control reserved bits not zero");

   ctl_value_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_rd && reg_addr == FILTER_CONTROL_OFS
      |=> reg_rdata[5:0] == $past({filter_capacitor_select, filter_bias_enable,
                                   filter_amplifier_enable}))
      else $error("filter control readback wrong");

   // main scenarios
   wr_ctl_c: cover property (@(posedge mclk) reg_wr && reg_addr == FILTER_CONTROL_OFS);

   rd_band_c: cover property (@(posedge mclk) reg_rd && reg_addr == OSC_BAND_OFS);

   wr_spare_c: cover property (@(posedge mclk) reg_wr && reg_addr == SPARE_THREE_OFS);

   rd_spare_c: cover property (@(posedge mclk) reg_rd && reg_addr == SPARE_TWO_OFS);

   band_move_c: cover property (@(posedge mclk) disable iff (sys_rst) $changed(band_q));
endmodule : pll_filter_and_scratch_regs

/* logic/pll_regs_pkg.sv */
// register offsets, field positions and reset values of the loop filter and spare bytes
package pll_regs_pkg;
   localparam int        ADDR_W             = 10;
   localparam int        DATA_W             = 8;
   localparam int        BAND_W             = 5;
   localparam int        CAP_W              = 4;
   localparam logic [9:0] FILTER_CONTROL_OFS = 10'h027;
   localparam logic [9:0] OSC_BAND_OFS       = 10'h028;
   localparam logic [9:0] SPARE_TWO_OFS      = 10'h0fe;
   localparam logic [9:0] SPARE_THREE_OFS    = 10'h0ff;
   localparam int        AMP_EN_POS         = 0;
   localparam int        BIAS_EN_POS        = 1;
   localparam int        CAP_LSB_POS        = 2;
   localparam logic [7:0] FILTER_CONTROL_RST = 8'h13;
   localparam logic [3:0] CAP_RST            = 4'h4;
   localparam logic       BIAS_EN_RST        = 1'b1;
   localparam logic       AMP_EN_RST         = 1'b1;
   localparam logic [7:0] SPARE_RST          = 8'h00;
   localparam logic [7:0] OSC_BAND_RST       = 8'h00;
endpackage : pll_regs_pkg

/* logic/spare_byte_store.sv */
// two-byte scratch store with registered read data
`timescale 1ns/1ns
module spare_byte_store
   import pll_regs_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // write port
   input  wire logic              wr_en,
   input  wire logic              wr_sel,
   input  wire logic [pll_regs_pkg::DATA_W-1:0] wr_data,
   // read port
   input  wire logic              rd_sel,
   output logic      [pll_regs_pkg::DATA_W-1:0] rd_data
);
   logic [DATA_W-1:0] mem_q [2];

   // scratch bytes only store, only the registered read port reads them
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_q[0] <= SPARE_RST;
         mem_q[1] <= SPARE_RST;
      end else if (wr_en) begin
         mem_q[wr_sel] <= wr_data;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= SPARE_RST;
      end else begin
         rd_data <= mem_q[rd_sel];
      end
   end
endmodule : spare_byte_store

/* dv/serial_host.sv */
// host model on the register port of the loop filter block
`timescale 1ns/1ns
module serial_host
   import pll_regs_pkg::*;
(
   // clock
   input  wire logic                            mclk,
   // register port
   output logic                                 reg_wr,
   output logic                                 reg_rd,
   output logic      [pll_regs_pkg::ADDR_W-1:0] reg_addr,
   output logic      [pll_regs_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic [pll_regs_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                            reg_rvalid
);
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = '0;
      reg_wdata = '0;
   end
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= (a == FILTER_CONTROL_OFS) ? (d & 8'h3f) : d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d  = 8'h00;
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge mclk);
         ok = (reg_rvalid === 1'b1);
         d  = reg_rdata;
      end
   endtask : rd
endmodule : serial_host

/* dv/tb_top.sv */
// self-checking bench for the loop filter and spare byte registers
`timescale 1ns/1ns
module tb_top;
   import pll_regs_pkg::*;
   logic              mclk, sys_rst, reg_wr, reg_rd, reg_rvalid, bias, amp;
   logic [ADDR_W-1:0] reg_addr, a;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, fc, s2, s3, d;
   logic [BAND_W-1:0] band;
   logic [CAP_W-1:0]  cap;
   logic [9:0]        pick [6] = '{FILTER_CONTROL_OFS, OSC_BAND_OFS, SPARE_TWO_OFS,
                                  SPARE_THREE_OFS, 10'h0fd, 10'h026};
   int                num_errors = 0, checked = 0, seed = 32'h4b59;
   pll_filter_and_scratch_regs pll_filter_and_scratch_regs_i (.mclk(mclk), .sys_rst(sys_rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .oscillator_band_readback(band),
      .filter_capacitor_select(cap), .filter_bias_enable(bias), .filter_amplifier_enable(amp));
   serial_host serial_host_i (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   function automatic logic [7:0] expv(input logic [9:0] x);
      case (x)
         FILTER_CONTROL_OFS: return fc;
         OSC_BAND_OFS:       return {3'b000, band};
         SPARE_TWO_OFS:      return s2;
         SPARE_THREE_OFS:    return s3;
         default:            return 8'h00;
      endcase
   endfunction : expv
   task automatic wrap_up();
      if (num_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [9:0] x);
      logic       ok;
      logic [7:0] v;
      serial_host_i.rd(x, v, ok);
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[FAIL] %0t no read answer", $time);
         wrap_up();
      end
      chk(v, expv(x));
   endtask : rd_chk
   task automatic check_all();
      chk({2'b00, cap, bias, amp}, fc);
      for (int k = 0; k < 4; k++) rd_chk(pick[k]);
   endtask : check_all
   initial begin
      sys_rst = 1'b1;
      band    = 5'h15;
      fc      = 8'h13;
      s2      = 8'h00;
      s3      = 8'h00;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      check_all();
      for (int i = 0; i < 60; i++) begin
         a = pick[$unsigned($random(seed)) % 6];
         d = 8'($random(seed));
         serial_host_i.wr(a, d);
         if (a == FILTER_CONTROL_OFS) fc = d & 8'h3f;
         if (a == SPARE_TWO_OFS) s2 = d;
         if (a == SPARE_THREE_OFS) s3 = d;
         if (i % 8 == 0) band <= 5'($random(seed));
         repeat (3) @(posedge mclk);
         chk({2'b00, cap, bias, amp}, fc);
         rd_chk(a);
      end
      // reset in mid-run brings the filter control and both spare bytes back to their defaults; band readback follows the input again
      sys_rst <= 1'b1;
      @(posedge mclk);
      sys_rst <= 1'b0;
      fc = 8'h13;
      s2 = 8'h00;
      s3 = 8'h00;
      check_all();
      wrap_up();
   end
endmodule : tb_top
